// ### rtl/prast_consts.svh
// Offsets, field positions, reset values and primitive kind codes of the rasterizer.
`ifndef PRAST_CONSTS_SVH
`define PRAST_CONSTS_SVH
`define PRAST_A_DOM_X 5'h00
`define PRAST_A_DOM_DX 5'h01
`define PRAST_A_MIN_X 5'h02
`define PRAST_A_MIN_DX 5'h03
`define PRAST_A_Y 5'h04
`define PRAST_A_DY 5'h05
`define PRAST_A_COUNT 5'h06
`define PRAST_A_MODE 5'h07
`define PRAST_A_RENDER 5'h08
`define PRAST_A_CONT 5'h09
`define PRAST_A_CONT_MINOR 5'h0a
`define PRAST_A_CONT_MAJOR 5'h0b
`define PRAST_A_CONT_SEG 5'h0c
`define PRAST_A_SYNC 5'h0d
`define PRAST_A_RECT_ORG 5'h0e
`define PRAST_A_RECT_EXT 5'h0f
`define PRAST_A_STATUS 5'h10
`define PRAST_R_KIND_LO 0
`define PRAST_R_KIND_HI 1
`define PRAST_R_SUBPIX 2
`define PRAST_R_XNEG 3
`define PRAST_R_YNEG 4
`define PRAST_M_LINE_RESTART 0
`define PRAST_MODE_RST 32'h0000_0000
`define PRAST_KIND_TRAP 2'h0
`define PRAST_KIND_LINE 2'h1
`define PRAST_KIND_POINT 2'h2
`define PRAST_KIND_RECT 2'h3
`endif

// ### rtl/prast_pkg.sv
// Types shared by the rasterizer design.
package prast_pkg;
	typedef struct packed {
		logic [4:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} prast_bus_t;
	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic subpix;
		logic sync;
	} prast_frag_t;
endpackage : prast_pkg

// ### rtl/prast_core.sv
// Primitive rasterizer: command registers, edge walker and fragment output.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "prast_consts.svh"
module prast_core (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_srst,
	// Register port.
	input wire prast_pkg::prast_bus_t i_bus,
	output logic [31:0] o_rdata,
	output logic o_cmd_ready,
	// Fragment stream.
	output prast_pkg::prast_frag_t o_frag,
	output logic o_frag_valid,
	input wire logic i_frag_ready,
	output logic o_busy
);
	import prast_pkg::*;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SPAN = 4'b0010,
		ST_STEP = 4'b0100,
		ST_LINE = 4'b1000
	} prast_state_t;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [31:0] dom_x_start_ff, dom_dx_ff, min_x_start_ff, min_dx_ff;
	logic [31:0] y_start_ff, y_step_ff, mode_ff, org_ff, ext_ff;
	logic [15:0] count_ff;
	logic [31:0] dom_x_ff, dom_dx_w_ff, min_x_ff, min_dx_w_ff;
	logic [31:0] y_ff, y_dx_w_ff;
	logic [15:0] lines_ff, px_ff, px_end_ff;
	logic [1:0] kind_ff;
	logic subpix_ff, xneg_ff, yneg_ff, sync_ff;
	logic pend_ff;
	logic [4:0] pend_addr_ff;
	logic [31:0] pend_word_ff;
	prast_state_t st_ff;
	prast_frag_t frag_ff;
	logic frag_valid_ff;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Command strobes; continues arriving while busy are parked.
	wire wr = i_bus.wr;
	wire [4:0] a = i_bus.addr;
	wire [31:0] wd = i_bus.wdata;
	wire idle = (st_ff == ST_IDLE) && !frag_valid_ff;
	wire is_cont = wr && (a == `PRAST_A_CONT || a == `PRAST_A_CONT_MINOR
		|| a == `PRAST_A_CONT_MAJOR || a == `PRAST_A_CONT_SEG);
	wire park = (is_cont || (wr && a == `PRAST_A_RENDER)) && !idle;
	wire run_pend = pend_ff && idle;
	wire [4:0] c_addr = run_pend ? pend_addr_ff : a;
	// A parked word is replayed as if it had just been written.
	wire [31:0] cw = run_pend ? pend_word_ff : wd;
	wire [15:0] c_cnt = cw[15:0];
	wire go_render = (wr && a == `PRAST_A_RENDER && idle && !pend_ff)
		|| (run_pend && pend_addr_ff == `PRAST_A_RENDER);
	wire run_cont = ((is_cont && idle && !pend_ff) || run_pend) && !go_render;
	wire out_free = !frag_valid_ff || i_frag_ready;
	// Span bounds: integer parts of the two edges, right edge excluded.
	wire [15:0] dom_i = dom_x_ff[31:16];
	wire [15:0] min_i = min_x_ff[31:16];
	wire ltr = $signed(min_i) >= $signed(dom_i);
	wire span_done = (px_ff == px_end_ff);
	wire [31:0] nxt_dom = dom_x_ff + dom_dx_w_ff;
	wire [31:0] nxt_min = min_x_ff + min_dx_w_ff;
	wire [31:0] nxt_y = y_ff + y_dx_w_ff;

	assign o_cmd_ready = !pend_ff;
	assign o_busy = !idle || pend_ff;
	assign o_frag = frag_ff;
	assign o_frag_valid = frag_valid_ff;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Host writes land in the loaders only; the walkers keep their own
	// copies, so loaders can be rewritten mid-primitive.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			dom_x_start_ff <= 32'h0;
			dom_dx_ff <= 32'h0;
			min_x_start_ff <= 32'h0;
			min_dx_ff <= 32'h0;
			y_start_ff <= 32'h0;
			y_step_ff <= 32'h0;
			count_ff <= 16'h0;
			mode_ff <= `PRAST_MODE_RST;
			org_ff <= 32'h0;
			ext_ff <= 32'h0;
		end else if (wr) begin
			unique case (a)
				`PRAST_A_DOM_X: dom_x_start_ff <= wd;
				`PRAST_A_DOM_DX: dom_dx_ff <= wd;
				`PRAST_A_MIN_X: min_x_start_ff <= wd;
				`PRAST_A_MIN_DX: min_dx_ff <= wd;
				`PRAST_A_Y: y_start_ff <= wd;
				`PRAST_A_DY: y_step_ff <= wd;
				`PRAST_A_COUNT: count_ff <= wd[15:0];
				`PRAST_A_MODE: mode_ff <= wd;
				`PRAST_A_RECT_ORG: org_ff <= wd;
				`PRAST_A_RECT_EXT: ext_ff <= wd;
				default: ;
			endcase
		end
	end

	// Read port; unmapped addresses read zero.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_rdata <= 32'h0;
		end else if (i_bus.rd) begin
			unique case (i_bus.addr)
				`PRAST_A_MODE: o_rdata <= mode_ff;
				`PRAST_A_STATUS: o_rdata <= {30'h0, pend_ff, o_busy};
				`PRAST_A_RECT_ORG: o_rdata <= org_ff;
				`PRAST_A_RECT_EXT: o_rdata <= ext_ff;
				default: o_rdata <= 32'h0;
			endcase
		end
	end

	// Parked command slot; a second one while full is dropped, host
	// must honour o_cmd_ready.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			pend_ff <= 1'b0;
			pend_addr_ff <= 5'h0;
			pend_word_ff <= 32'h0;
		end else if (park && !pend_ff) begin
			pend_ff <= 1'b1;
			pend_addr_ff <= a;
			pend_word_ff <= wd;
		end else if (run_pend) begin
			pend_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Walker
	// ----------------------------------------
	// Edge walking: one fragment per cycle inside a span or line while downstream accepts; each span row adds a ST_STEP cycle and an end cycle.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			st_ff <= ST_IDLE;
			dom_x_ff <= 32'h0;
			dom_dx_w_ff <= 32'h0;
			min_x_ff <= 32'h0;
			min_dx_w_ff <= 32'h0;
			y_ff <= 32'h0;
			y_dx_w_ff <= 32'h0;
			lines_ff <= 16'h0;
			px_ff <= 16'h0;
			px_end_ff <= 16'h0;
			kind_ff <= `PRAST_KIND_TRAP;
			subpix_ff <= 1'b0;
			xneg_ff <= 1'b0;
			yneg_ff <= 1'b0;
			sync_ff <= 1'b0;
			frag_ff <= '0;
			frag_valid_ff <= 1'b0;
		end else begin
			if (i_frag_ready)
				frag_valid_ff <= 1'b0;
			unique case (st_ff)
				ST_IDLE: begin
					if (go_render) begin
						kind_ff <= cw[`PRAST_R_KIND_HI:`PRAST_R_KIND_LO];
						subpix_ff <= cw[`PRAST_R_SUBPIX];
						xneg_ff <= cw[`PRAST_R_XNEG];
						yneg_ff <= cw[`PRAST_R_YNEG];
						dom_dx_w_ff <= dom_dx_ff;
						min_dx_w_ff <= min_dx_ff;
						y_dx_w_ff <= y_step_ff;
						unique case (cw[`PRAST_R_KIND_HI:`PRAST_R_KIND_LO])
							`PRAST_KIND_TRAP: begin
								dom_x_ff <= dom_x_start_ff;
								min_x_ff <= min_x_start_ff;
								y_ff <= y_start_ff;
								lines_ff <= count_ff;
								st_ff <= (count_ff == 16'h0) ? ST_IDLE : ST_STEP;
							end
							`PRAST_KIND_LINE: begin
								dom_x_ff <= dom_x_start_ff;
								y_ff <= y_start_ff;
								lines_ff <= count_ff;
								st_ff <= (count_ff == 16'h0) ? ST_IDLE : ST_LINE;
							end
							`PRAST_KIND_POINT: begin
								frag_ff <= '{x: dom_x_start_ff[31:16],
									y: y_start_ff[31:16], subpix: 1'b0,
									sync: sync_ff};
								frag_valid_ff <= 1'b1;
								sync_ff <= 1'b0;
							end
							default: begin
								// Rectangle as integer trapezoid walk.
								dom_x_ff <= {(cw[`PRAST_R_XNEG] ? org_ff[15:0]
									+ ext_ff[15:0] : org_ff[15:0]), 16'h0};
								min_x_ff <= {(cw[`PRAST_R_XNEG] ? org_ff[15:0]
									: org_ff[15:0] + ext_ff[15:0]), 16'h0};
								y_ff <= {(cw[`PRAST_R_YNEG] ? org_ff[31:16]
									+ ext_ff[31:16] - 16'h1 : org_ff[31:16]), 16'h0};
								y_dx_w_ff <= cw[`PRAST_R_YNEG] ? 32'hffff_0000
									: 32'h0001_0000;
								dom_dx_w_ff <= 32'h0;
								min_dx_w_ff <= 32'h0;
								lines_ff <= ext_ff[31:16];
								st_ff <= (ext_ff[31:16] == 16'h0) ? ST_IDLE : ST_STEP;
							end
						endcase
					end else if (run_cont) begin
						lines_ff <= c_cnt;
						if (c_addr == `PRAST_A_CONT_MINOR) begin
							min_x_ff <= min_x_start_ff;
							min_dx_w_ff <= min_dx_ff;
						end else if (c_addr == `PRAST_A_CONT_MAJOR) begin
							dom_x_ff <= dom_x_start_ff;
							dom_dx_w_ff <= dom_dx_ff;
						end else if (c_addr == `PRAST_A_CONT_SEG) begin
							dom_dx_w_ff <= dom_dx_ff;
							y_dx_w_ff <= y_step_ff;
							if (mode_ff[`PRAST_M_LINE_RESTART]) begin
								dom_x_ff <= {dom_x_ff[31:16], 16'h8000};
								y_ff <= {y_ff[31:16], 16'h8000};
							end
						end
						if (c_cnt != 16'h0)
							st_ff <= (kind_ff == `PRAST_KIND_LINE) ? ST_LINE : ST_STEP;
					end
				end
				ST_STEP: begin
					// Load span ends for the current scanline.
					px_ff <= dom_i;
					px_end_ff <= min_i;
					st_ff <= ST_SPAN;
				end
				ST_SPAN: begin
					if (out_free) begin
						if (span_done) begin
							dom_x_ff <= nxt_dom;
							min_x_ff <= nxt_min;
							y_ff <= nxt_y;
							lines_ff <= lines_ff - 16'h1;
							st_ff <= (lines_ff == 16'h1) ? ST_IDLE : ST_STEP;
						end else begin
							// Right-to-left spans emit the pixel left of px.
							frag_ff <= '{x: ltr ? px_ff : px_ff - 16'h1,
								y: y_ff[31:16], subpix: subpix_ff,
								sync: sync_ff};
							frag_valid_ff <= 1'b1;
							sync_ff <= 1'b0;
							px_ff <= ltr ? px_ff + 16'h1 : px_ff - 16'h1;
						end
					end
				end
				ST_LINE: begin
					if (out_free) begin
						dom_x_ff <= nxt_dom;
						y_ff <= nxt_y;
						frag_ff <= '{x: nxt_dom[31:16], y: nxt_y[31:16],
							subpix: 1'b0, sync: sync_ff};
						frag_valid_ff <= 1'b1;
						sync_ff <= 1'b0;
						lines_ff <= lines_ff - 16'h1;
						if (lines_ff == 16'h1)
							st_ff <= ST_IDLE;
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
			// Sync marks the next fragment as a flush barrier; the set
			// wins over an emission clearing it in the same cycle.
			if (wr && a == `PRAST_A_SYNC)
				sync_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_point_single: assert property (@(posedge i_mclk) disable iff (i_srst)
		go_render && cw[1:0] == `PRAST_KIND_POINT |=> frag_valid_ff
		&& frag_ff.x == $past(dom_x_start_ff[31:16]) && st_ff == ST_IDLE)
		else $error("point did not emit one fragment");
	a_render_starts: assert property (@(posedge i_mclk) disable iff (i_srst)
		go_render && cw[1:0] == `PRAST_KIND_TRAP && count_ff != 16'h0
		|=> st_ff == ST_STEP && lines_ff == $past(count_ff))
		else $error("render did not start walk");
	a_cont_parked: assert property (@(posedge i_mclk) disable iff (i_srst)
		is_cont && !idle && !pend_ff |=> pend_ff)
		else $error("continue while busy lost");
	a_minor_reload: assert property (@(posedge i_mclk) disable iff (i_srst)
		run_cont && c_addr == `PRAST_A_CONT_MINOR && !go_render
		|=> min_x_ff == $past(min_x_start_ff))
		else $error("minor edge not reloaded");
	a_major_only: assert property (@(posedge i_mclk) disable iff (i_srst)
		run_cont && c_addr == `PRAST_A_CONT_MAJOR
		|=> min_x_ff == $past(min_x_ff) && dom_x_ff == $past(dom_x_start_ff))
		else $error("major continue touched minor");
	a_plain_keeps: assert property (@(posedge i_mclk) disable iff (i_srst)
		run_cont && c_addr == `PRAST_A_CONT |=> dom_x_ff == $past(dom_x_ff))
		else $error("plain continue reloaded edge");
	a_walker_isolated: assert property (@(posedge i_mclk) disable iff (i_srst)
		st_ff == ST_SPAN && !span_done |=> dom_x_ff == $past(dom_x_ff))
		else $error("edge moved inside span");
	a_sync_marked: assert property (@(posedge i_mclk) disable iff (i_srst)
		wr && a == `PRAST_A_SYNC |=> sync_ff)
		else $error("sync not recorded");
	a_line_steps: assert property (@(posedge i_mclk) disable iff (i_srst)
		st_ff == ST_LINE && out_free |=> frag_valid_ff
		&& dom_x_ff == $past(dom_x_ff) + $past(dom_dx_w_ff))
		else $error("line step wrong");
	a_mode_holds: assert property (@(posedge i_mclk) disable iff (i_srst)
		!(wr && a == `PRAST_A_MODE) |=> mode_ff == $past(mode_ff))
		else $error("mode changed without write");
endmodule : prast_core

// ### verification/prast_sink.sv
// Downstream fragment sink that accepts promptly or every other cycle.
`timescale 1ns/1ps
module prast_sink (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_srst,
	// Fragment stream and pacing.
	input wire prast_pkg::prast_frag_t i_frag,
	input wire logic i_valid,
	input wire logic i_slow,
	output logic o_ready
);
	import prast_pkg::*;
	// Accepted fragments in arrival order, and hold violations seen.
	prast_frag_t q[$];
	int errs = 0;
	prast_frag_t last_ff;
	logic stall_ff;
	// Ready toggles when slow, so the source must hold a refused fragment.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_ready <= 1'b1;
			stall_ff <= 1'b0;
		end else begin
			o_ready <= i_slow ? ~o_ready : 1'b1;
			stall_ff <= i_valid & ~o_ready;
			last_ff <= i_frag;
			if (i_valid & o_ready) q.push_back(i_frag);
			if (stall_ff & (!i_valid | (i_frag !== last_ff)))
				errs <= errs + 1;
		end
	end
endmodule : prast_sink

// ### verification/tb.sv
// Self-checking bench for the primitive rasterizer.
`timescale 1ns/1ps
`include "prast_consts.svh"
module tb;
	import prast_pkg::*;
	localparam logic [31:0] ONE = 32'h0001_0000;
	logic i_mclk = 1'b0;
	logic i_srst;
	logic slow;
	prast_bus_t bus;
	logic [31:0] rdata;
	logic cmd_ready, frag_valid, frag_ready, busy;
	prast_frag_t frag;
	int fail_count = 0;
	int comparisons = 0;
	// Reversed fill covers the same pixels from the opposite corner.
	logic [15:0] rx [8] = '{16'h1, 16'h2, 16'h1, 16'h2,
		16'h2, 16'h1, 16'h2, 16'h1};
	logic [15:0] ry [8] = '{16'h2, 16'h2, 16'h3, 16'h3,
		16'h3, 16'h3, 16'h2, 16'h2};
	// Clock at 10 MHz.
	always #50 i_mclk = ~i_mclk;
	prast_core dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_bus(bus),
		.o_rdata(rdata), .o_cmd_ready(cmd_ready), .o_frag(frag),
		.o_frag_valid(frag_valid), .i_frag_ready(frag_ready),
		.o_busy(busy));
	prast_sink sink (.i_mclk(i_mclk), .i_srst(i_srst), .i_frag(frag),
		.i_valid(frag_valid), .i_slow(slow), .o_ready(frag_ready));
	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk
	task automatic fxy(input int i, input logic [15:0] x,
		input logic [15:0] y);
		chk({sink.q[i].x, sink.q[i].y}, {x, y}, "fragment position");
	endtask : fxy
	// One-cycle register write and read on the plain port.
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge i_mclk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge i_mclk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	// Waits, bounded, until the block has gone idle.
	task automatic drain;
		int k;
		k = 0;
		repeat (4) @(posedge i_mclk);
		#1;
		while (busy !== 1'b0 && k < 3000) begin
			@(posedge i_mclk);
			#1 k++;
		end
	endtask : drain
	task automatic pace(input logic s);
		@(posedge i_mclk);
		slow <= s;
		sink.q.delete();
	endtask : pace
	task automatic t_regs;
		logic [31:0] d;
		chk({busy, cmd_ready, frag_valid}, 3'b010, "reset");
		rd(`PRAST_A_STATUS, d);
		chk(d, 32'h0, "idle status");
		wr(`PRAST_A_MODE, 32'h1);
		rd(`PRAST_A_MODE, d);
		chk(d, 32'h1, "mode readback");
		wr(5'h1f, 32'h3);
		drain;
		chk(sink.q.size(), 0, "unmapped write");
	endtask : t_regs
	task automatic t_point;
		pace(1'b0);
		wr(`PRAST_A_DOM_X, 32'h0005_8000);
		wr(`PRAST_A_Y, 32'h0007_0000);
		wr(`PRAST_A_RENDER, 32'h2);
		drain;
		chk(sink.q.size(), 1, "point count");
		fxy(0, 16'h5, 16'h7);
	endtask : t_point
	task automatic t_trap;
		pace(1'b1);
		wr(`PRAST_A_DOM_X, 32'h0005_0000);
		wr(`PRAST_A_MIN_X, 32'h0002_0000);
		wr(`PRAST_A_DOM_DX, 32'h0);
		wr(`PRAST_A_MIN_DX, 32'h0);
		wr(`PRAST_A_Y, 32'h000a_0000);
		wr(`PRAST_A_DY, 32'hffff_0000);
		wr(`PRAST_A_COUNT, 32'h2);
		wr(`PRAST_A_RENDER, 32'h0);
		drain;
		chk(sink.q.size(), 6, "two rows");
		for (int i = 0; i < 6; i++) begin
			chk(sink.q[i].x, 4 - i % 3, "span");
		end
		chk(sink.q[2].y, 16'ha, "row");
		chk(sink.q[3].y, 16'h9, "step");
		chk(sink.errs, 0, "fragment held");
	endtask : t_trap
	task automatic t_minor;
		pace(1'b1);
		wr(`PRAST_A_DOM_X, 32'h0);
		wr(`PRAST_A_MIN_X, 32'h0006_0000);
		wr(`PRAST_A_COUNT, 32'h1);
		wr(`PRAST_A_RENDER, 32'h0);
		wr(`PRAST_A_MIN_X, 32'h0003_0000);
		wr(`PRAST_A_CONT_MINOR, 32'h1);
		#1 chk(cmd_ready, 1'b0, "parked");
		drain;
		chk(sink.q.size(), 9, "reload count");
		for (int i = 0; i < 9; i++) begin
			chk(sink.q[i].x, i < 6 ? i : i - 6, "reload");
		end
	endtask : t_minor
	task automatic t_cont;
		pace(1'b0);
		wr(`PRAST_A_MIN_X, 32'h0002_0000);
		wr(`PRAST_A_MIN_DX, ONE);
		wr(`PRAST_A_RENDER, 32'h0);
		wr(`PRAST_A_CONT, 32'h1);
		drain;
		chk(sink.q.size(), 5, "carried edge");
		chk(sink.q[4].x, 16'h2, "carried minor edge");
		chk(sink.q[2].x, 16'h0, "held major edge");
	endtask : t_cont
	task automatic t_line;
		for (int m = 0; m < 2; m++) begin
			pace(1'b0);
			wr(`PRAST_A_MODE, m);
			wr(`PRAST_A_DOM_X, 32'h0);
			wr(`PRAST_A_DOM_DX, ONE);
			wr(`PRAST_A_Y, 32'h0);
			wr(`PRAST_A_DY, 32'h0000_8000);
			wr(`PRAST_A_COUNT, 32'h3);
			wr(`PRAST_A_RENDER, 32'h1);
			wr(`PRAST_A_DY, ONE);
			wr(`PRAST_A_CONT_SEG, 32'h2);
			drain;
			chk(sink.q.size(), 5, "line length");
			for (int i = 0; i < 5; i++) begin
				fxy(i, 16'(i + 1), 16'(i < 3 ? (i + 1) / 2 : i - 1));
			end
		end
	endtask : t_line
	task automatic t_sync;
		pace(1'b0);
		wr(`PRAST_A_SYNC, 32'h0);
		wr(`PRAST_A_RENDER, 32'h2);
		wr(`PRAST_A_RENDER, 32'h4);
		drain;
		chk({sink.q[0].sync, sink.q[0].subpix}, 2'h2, "sync");
		chk({sink.q[1].sync, sink.q[1].subpix}, 2'h1, "subpix");
	endtask : t_sync
	task automatic t_rect;
		pace(1'b0);
		wr(`PRAST_A_RECT_ORG, 32'h0002_0001);
		wr(`PRAST_A_RECT_EXT, 32'h0002_0002);
		wr(`PRAST_A_RENDER, 32'h3);
		wr(`PRAST_A_RENDER, 32'h1b);
		drain;
		chk(sink.q.size(), 8, "rect count");
		for (int i = 0; i < 8; i++) begin
			fxy(i, rx[i], ry[i]);
		end
	endtask : t_rect
	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run;
		$display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	// Main sequence after a four-cycle reset.
	initial begin
		i_srst = 1'b1;
		slow = 1'b0;
		bus = '0;
		repeat (4) @(posedge i_mclk);
		i_srst <= 1'b0;
		@(posedge i_mclk);
		#1 t_regs;
		t_point;
		t_trap;
		t_minor;
		t_cont;
		t_line;
		t_sync;
		t_rect;
		complete_run;
	end
	// Watchdog well beyond the expected run length.
	initial begin
		repeat (20000) @(posedge i_mclk);
		fail_count++;
		complete_run;
	end
endmodule : tb
